// *** hdl/mmuat_defines.svh ***
`ifndef MMUAT_DEFINES_SVH
`define MMUAT_DEFINES_SVH

// ****************************************
// register byte addresses
// ****************************************
`define MMUAT_A_EHI 8'h00
`define MMUAT_A_LO0 8'h08
`define MMUAT_A_LO1 8'h10
`define MMUAT_A_PMASK 8'h18
`define MMUAT_A_INDEX 8'h20
`define MMUAT_A_WIRED 8'h28
`define MMUAT_A_RANDOM 8'h30
`define MMUAT_A_CONFIG 8'h38
`define MMUAT_A_STATUS 8'h40
`define MMUAT_A_CMD 8'h48

// ****************************************
// field positions
// ****************************************
`define MMUAT_EHI_VPN2 39:13
`define MMUAT_EHI_SID 7:0
`define MMUAT_LO_PFN 29:6
`define MMUAT_LO_ATTR 5:3
`define MMUAT_LO_V 1
`define MMUAT_LO_G 0
`define MMUAT_PM_MASK 24:13
`define MMUAT_CFG_UK 30:28
`define MMUAT_CFG_USR 27:25
`define MMUAT_CFG_KC 2:0
`define MMUAT_ST_ERL 2
`define MMUAT_ST_TS 21
`define MMUAT_CMD_WI 0
`define MMUAT_CMD_WR 1

// ****************************************
// write masks, reset values, segments
// ****************************************
`define MMUAT_EHI_WM 64'h0000_00FF_FFFF_E0FF
`define MMUAT_LO_WM 64'h0000_0000_3FFF_FFFB
`define MMUAT_CFG_WM 64'h0000_0000_7E00_0007
`define MMUAT_CFG_RST 64'h0000_0000_2400_0002
`define MMUAT_ERL_RST 1'h1
`define MMUAT_ATTR_UNC 3'h2
`define MMUAT_SEG_KC 3'h4
`define MMUAT_SEG_KU 3'h5

`endif

// *** hdl/mmuat_pkg.sv ***
package mmuat_pkg;

  typedef struct packed {
    logic [26:0] vpn2;
    logic [11:0] mask;
    logic [7:0] sid;
    logic g;
    logic vld;
    logic [23:0] pfn0;
    logic [23:0] pfn1;
    logic [2:0] c0;
    logic [2:0] c1;
    logic v0;
    logic v1;
  } mmuat_jentry_t;

  typedef struct packed {
    logic [27:0] virtual_page_number;
    logic [7:0] sid;
    logic g;
    logic vld;
    logic [23:0] page_frame_number;
    logic [2:0] attr;
  } mmuat_uentry_t;

  typedef struct packed {
    logic hit;
    logic v;
    logic g;
    logic [23:0] page_frame_number;
    logic [2:0] attr;
  } mmuat_jres_t;

  typedef enum logic [1:0] {ST_IDLE, ST_JLOOK, ST_RELOOK} mmuat_state_t;

  typedef enum logic [2:0] {
    CCA_WT_NOALLOC, CCA_WT_ALLOC, CCA_UNCACHED, CCA_WRITE_BACK, CCA_UNC_ACCEL
  } mmuat_cca_t;

endpackage

// *** hdl/mmuat_utlb_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mmuat_utlb_if;
  import mmuat_pkg::*;
  logic [27:0] lk_vpn;
  logic [7:0] lk_sid;
  logic hit;
  logic [23:0] page_frame_number;
  logic [2:0] attr;
  logic fill;
  mmuat_uentry_t fill_e;
  logic flush;
  modport owner (output lk_vpn, lk_sid, fill, fill_e, flush, input hit, page_frame_number, attr);
  modport tlb (input lk_vpn, lk_sid, fill, fill_e, flush, output hit, page_frame_number, attr);
endinterface
`default_nettype wire

// *** hdl/mmuat_micro_tlb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmuat_micro_tlb
  import mmuat_pkg::*;
#(
  parameter int ENTRIES = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  mmuat_utlb_if.tlb u
);
  localparam int PW = $clog2(ENTRIES);

  typedef struct packed {
    mmuat_uentry_t [ENTRIES-1:0] e;
    logic [PW-1:0] ptr;
  } mmuat_ust_t;

  mmuat_ust_t q_ff;
  mmuat_ust_t nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    u.hit = 1'b0;
    u.page_frame_number = '0;
    u.attr = '0;
    for (int i = 0; i < ENTRIES; i++)
    begin
      // only 4k sub-pages are held, so the tag is the full page number
      if (q_ff.e[i].vld && q_ff.e[i].virtual_page_number == u.lk_vpn && (q_ff.e[i].g || q_ff.e[i].sid == u.lk_sid))
      begin
        u.hit = 1'b1;
        u.page_frame_number = q_ff.e[i].page_frame_number;
        u.attr = q_ff.e[i].attr;
      end
    end
    // a flush beats a fill: the fill may hold a stale mapping
    if (u.flush)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        nxt_q.e[i].vld = 1'b0;
      end
    end
    else if (u.fill)
    begin
      nxt_q.e[q_ff.ptr] = u.fill_e;
      nxt_q.ptr = (q_ff.ptr == PW'(ENTRIES - 1)) ? '0 : q_ff.ptr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      q_ff <= '0;
    else if (clk_en)
      q_ff <= nxt_q;
  end
endmodule
`default_nettype wire

// *** hdl/mmuat_fixed_map.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mmuat_defines.svh"
module mmuat_fixed_map
(
  input wire logic [63:0] va,
  input wire logic error_level_bit,
  input wire logic fixed,
  input wire logic [2:0] uk_attr,
  input wire logic [2:0] usr_attr,
  input wire logic [2:0] kc_attr,
  output logic unmapped,
  output logic [35:0] paddr,
  output logic [2:0] attr,
  output logic addr_err
);
  logic sext;
  logic useg;
  logic kc;
  logic ku;

  always_comb
  begin
    sext = va[63:32] == {32{va[31]}};
    useg = !va[31];
    kc = va[31:29] == `MMUAT_SEG_KC;
    ku = va[31:29] == `MMUAT_SEG_KU;
    // both kernel windows start at physical zero
    paddr = {4'h0, (kc || ku) ? {3'h0, va[28:0]} : va[31:0]};
    if (useg)
      attr = error_level_bit ? `MMUAT_ATTR_UNC : usr_attr;
    else if (kc)
      attr = kc_attr;
    else if (ku)
      attr = `MMUAT_ATTR_UNC;
    else
      attr = uk_attr;
    if (fixed)
    begin
      unmapped = 1'b1;
      addr_err = !sext;
    end
    else
    begin
      unmapped = sext && (kc || ku || (useg && error_level_bit));
      addr_err = !(sext || (va[61:40] == '0 && va[63:62] != 2'h2));
    end
  end
endmodule
`default_nettype wire

// *** hdl/mmuat_top.sv ***
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mmuat_defines.svh"
module mmuat_top
  import mmuat_pkg::*;
#(
  parameter bit USE_FMT = 1'b0,
  parameter int JOINT_TRANSLATION_BUFFER_PAIRS = 16,
  parameter int UTLB_ENTRIES = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  input wire logic ls_req,
  input wire logic [63:0] ls_vaddr,
  output logic ls_busy,
  output logic ls_done,
  output logic [35:0] ls_paddr,
  output logic [2:0] ls_attr,
  output mmuat_cca_t ls_cls,
  output logic ls_refill_exc,
  output logic ls_invalid_exc,
  output logic ls_addr_err,
  input wire logic if_req,
  input wire logic [63:0] if_vaddr,
  output logic if_done,
  output logic [23:0] if_pfn,
  output logic [2:0] if_attr,
  output logic if_refill_exc,
  output logic if_invalid_exc,
  output logic mcheck_exc
);
  localparam int IW = $clog2(JOINT_TRANSLATION_BUFFER_PAIRS);
  localparam logic [IW-1:0] TOP = IW'(JOINT_TRANSLATION_BUFFER_PAIRS - 1);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mmuat_jentry_t [JOINT_TRANSLATION_BUFFER_PAIRS-1:0] jt;
    logic [63:0] ehi;
    logic [63:0] lo0;
    logic [63:0] lo1;
    logic [11:0] pmask;
    logic [63:0] cfg;
    logic error_level_bit;
    logic ts;
    logic [IW-1:0] index;
    logic [IW-1:0] wired;
    logic [IW-1:0] rnd;
    mmuat_state_t st;
    logic [63:0] dva;
    logic ipend;
    logic [63:0] iva;
    logic [63:0] rdata;
    logic busy;
    logic done;
    logic [35:0] paddr;
    logic [2:0] attr;
    mmuat_cca_t cls;
    logic rexc;
    logic dinv;
    logic aerr;
    logic idone;
    logic [23:0] ipfn;
    logic [2:0] iattr;
    logic irexc;
    logic iinv;
    logic mchk;
  } mmuat_top_st_t;

  mmuat_top_st_t q_ff;
  mmuat_top_st_t nxt_q;

  logic f_unm;
  logic [35:0] f_pa;
  logic [2:0] f_attr;
  logic f_aerr;

  mmuat_utlb_if u();

  mmuat_micro_tlb #(.ENTRIES(UTLB_ENTRIES)) u_data_micro_tlb
  (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .u(u)
  );

  mmuat_fixed_map u_fmt
  (
    .va(ls_vaddr),
    .error_level_bit(q_ff.error_level_bit),
    .fixed(USE_FMT),
    .uk_attr(q_ff.cfg[`MMUAT_CFG_UK]),
    .usr_attr(q_ff.cfg[`MMUAT_CFG_USR]),
    .kc_attr(q_ff.cfg[`MMUAT_CFG_KC]),
    .unmapped(f_unm),
    .paddr(f_pa),
    .attr(f_attr),
    .addr_err(f_aerr)
  );

  // ****************************************
  // functions
  // ****************************************
  function automatic mmuat_cca_t cca_decode(input logic [2:0] a);
    mmuat_cca_t c;
    unique case (a)
      3'h0: c = CCA_WT_NOALLOC;
      3'h1: c = CCA_WT_ALLOC;
      3'h2: c = CCA_UNCACHED;
      3'h3, 3'h4, 3'h5, 3'h6: c = CCA_WRITE_BACK;
      3'h7: c = CCA_UNC_ACCEL;
    endcase
    return c;
  endfunction

  // mask bits are the page-number bits left out of the compare
  function automatic logic vpn_eq(input logic [26:0] a, input logic [26:0] b, input logic [11:0] mask);
    logic [26:0] m;
    m = {15'h0000, mask};
    return (a & ~m) == (b & ~m);
  endfunction

  // highest address bit below the compared ones picks even or odd
  function automatic logic odd_sel(input logic [63:0] va, input logic [11:0] mask);
    logic [12:0] ext;
    logic [12:0] oh;
    ext = {mask, 1'b1};
    oh = ext & ~{1'b0, ext[12:1]};
    return |(va[24:12] & oh);
  endfunction

  function automatic mmuat_jres_t jt_lookup(input mmuat_jentry_t [JOINT_TRANSLATION_BUFFER_PAIRS-1:0] jt, input logic [63:0] va,
                                            input logic [7:0] sid);
    mmuat_jres_t r;
    logic odd;
    logic [23:0] page_frame_number;
    logic [35:0] off;
    logic [35:0] pa;
    r = '0;
    odd = 1'b0;
    page_frame_number = '0;
    off = '0;
    pa = '0;
    for (int i = 0; i < JOINT_TRANSLATION_BUFFER_PAIRS; i++)
    begin
      if (jt[i].vld && vpn_eq(jt[i].vpn2, va[39:13], jt[i].mask) && (jt[i].g || jt[i].sid == sid))
      begin
        odd = odd_sel(va, jt[i].mask);
        page_frame_number = odd ? jt[i].pfn1 : jt[i].pfn0;
        off = {11'h000, jt[i].mask, 13'h1FFF} >> 1;
        pa = ({page_frame_number, 12'h000} & ~off) | (va[35:0] & off);
        r.hit = 1'b1;
        r.v = odd ? jt[i].v1 : jt[i].v0;
        r.g = jt[i].g;
        r.page_frame_number = pa[35:12];
        r.attr = odd ? jt[i].c1 : jt[i].c0;
      end
    end
    return r;
  endfunction

  function automatic logic jt_clash(input mmuat_jentry_t [JOINT_TRANSLATION_BUFFER_PAIRS-1:0] jt, input logic [IW-1:0] idx,
                                    input mmuat_jentry_t n);
    logic c;
    c = 1'b0;
    for (int i = 0; i < JOINT_TRANSLATION_BUFFER_PAIRS; i++)
    begin
      if (IW'(i) != idx && jt[i].vld && vpn_eq(jt[i].vpn2, n.vpn2, jt[i].mask | n.mask) &&
          (jt[i].g || n.g || jt[i].sid == n.sid))
        c = 1'b1;
    end
    return c;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    mmuat_jentry_t ne;
    logic [IW-1:0] widx;
    logic [63:0] jva;
    logic [63:0] sr;
    mmuat_jres_t jr;
    logic igo;
    ne = '0;
    widx = '0;
    jva = '0;
    sr = '0;
    jr = '0;
    igo = 1'b0;
    nxt_q = q_ff;
    nxt_q.rdata = '0;
    nxt_q.done = 1'b0;
    nxt_q.rexc = 1'b0;
    nxt_q.dinv = 1'b0;
    nxt_q.aerr = 1'b0;
    nxt_q.idone = 1'b0;
    nxt_q.irexc = 1'b0;
    nxt_q.iinv = 1'b0;
    nxt_q.mchk = 1'b0;
    u.lk_vpn = (q_ff.st == ST_IDLE) ? ls_vaddr[39:12] : q_ff.dva[39:12];
    u.lk_sid = q_ff.ehi[`MMUAT_EHI_SID];
    u.fill = 1'b0;
    u.fill_e = '0;
    u.flush = 1'b0;

    // wraps to the top so that locked low entries are never picked
    if (q_ff.rnd <= q_ff.wired || q_ff.rnd == '0)
      nxt_q.rnd = TOP;
    else
      nxt_q.rnd = q_ff.rnd - 1'b1;

    if (reg_wr)
    begin
      case (reg_addr)
        `MMUAT_A_EHI: nxt_q.ehi = reg_wdata & `MMUAT_EHI_WM;
        `MMUAT_A_LO0: nxt_q.lo0 = reg_wdata & `MMUAT_LO_WM;
        `MMUAT_A_LO1: nxt_q.lo1 = reg_wdata & `MMUAT_LO_WM;
        `MMUAT_A_PMASK: nxt_q.pmask = reg_wdata[`MMUAT_PM_MASK];
        `MMUAT_A_INDEX: nxt_q.index = reg_wdata[IW-1:0];
        `MMUAT_A_WIRED:
        begin
          nxt_q.wired = reg_wdata[IW-1:0];
          nxt_q.rnd = TOP;
        end
        `MMUAT_A_CONFIG: nxt_q.cfg = reg_wdata & `MMUAT_CFG_WM;
        `MMUAT_A_STATUS:
        begin
          nxt_q.error_level_bit = reg_wdata[`MMUAT_ST_ERL];
          if (!reg_wdata[`MMUAT_ST_TS])
            nxt_q.ts = 1'b0;
        end
        `MMUAT_A_CMD:
        begin
          widx = reg_wdata[`MMUAT_CMD_WR] ? q_ff.rnd : q_ff.index;
          ne.vpn2 = q_ff.ehi[`MMUAT_EHI_VPN2];
          ne.sid = q_ff.ehi[`MMUAT_EHI_SID];
          ne.mask = q_ff.pmask;
          ne.g = q_ff.lo0[`MMUAT_LO_G] & q_ff.lo1[`MMUAT_LO_G];
          ne.vld = 1'b1;
          ne.pfn0 = q_ff.lo0[`MMUAT_LO_PFN];
          ne.pfn1 = q_ff.lo1[`MMUAT_LO_PFN];
          ne.c0 = q_ff.lo0[`MMUAT_LO_ATTR];
          ne.c1 = q_ff.lo1[`MMUAT_LO_ATTR];
          ne.v0 = q_ff.lo0[`MMUAT_LO_V];
          ne.v1 = q_ff.lo1[`MMUAT_LO_V];
          if (reg_wdata[`MMUAT_CMD_WI] || reg_wdata[`MMUAT_CMD_WR])
          begin
            if (jt_clash(q_ff.jt, widx, ne))
            begin
              nxt_q.ts = 1'b1;
              nxt_q.mchk = 1'b1;
            end
            else
            begin
              nxt_q.jt[widx] = ne;
              u.flush = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    if (reg_rd)
    begin
      sr[`MMUAT_ST_ERL] = q_ff.error_level_bit;
      sr[`MMUAT_ST_TS] = q_ff.ts;
      case (reg_addr)
        `MMUAT_A_EHI: nxt_q.rdata = q_ff.ehi;
        `MMUAT_A_LO0: nxt_q.rdata = q_ff.lo0;
        `MMUAT_A_LO1: nxt_q.rdata = q_ff.lo1;
        `MMUAT_A_PMASK: nxt_q.rdata = {39'h0, q_ff.pmask, 13'h0000};
        `MMUAT_A_INDEX: nxt_q.rdata = 64'(q_ff.index);
        `MMUAT_A_WIRED: nxt_q.rdata = 64'(q_ff.wired);
        `MMUAT_A_RANDOM: nxt_q.rdata = 64'(q_ff.rnd);
        `MMUAT_A_CONFIG: nxt_q.rdata = q_ff.cfg;
        `MMUAT_A_STATUS: nxt_q.rdata = sr;
        default: nxt_q.rdata = '0;
      endcase
    end

    // one lookup port: the data side owns it while in ST_JLOOK
    igo = q_ff.ipend && q_ff.st != ST_JLOOK;
    jva = (q_ff.st == ST_JLOOK) ? q_ff.dva : q_ff.iva;
    jr = jt_lookup(q_ff.jt, jva, q_ff.ehi[`MMUAT_EHI_SID]);

    unique case (q_ff.st)
      ST_IDLE:
      begin
        if (ls_req)
        begin
          nxt_q.done = 1'b1;
          if (f_aerr)
            nxt_q.aerr = 1'b1;
          else if (f_unm)
          begin
            nxt_q.paddr = f_pa;
            nxt_q.attr = f_attr;
          end
          else if (u.hit)
          begin
            nxt_q.paddr = {u.page_frame_number, ls_vaddr[11:0]};
            nxt_q.attr = u.attr;
          end
          else
          begin
            nxt_q.done = 1'b0;
            nxt_q.st = ST_JLOOK;
            nxt_q.dva = ls_vaddr;
          end
        end
      end
      ST_JLOOK:
      begin
        nxt_q.done = !(jr.hit && jr.v);
        nxt_q.rexc = !jr.hit;
        nxt_q.dinv = jr.hit && !jr.v;
        nxt_q.st = (jr.hit && jr.v) ? ST_RELOOK : ST_IDLE;
        u.fill = jr.hit && jr.v;
        u.fill_e.virtual_page_number = q_ff.dva[39:12];
        u.fill_e.sid = q_ff.ehi[`MMUAT_EHI_SID];
        u.fill_e.g = jr.g;
        u.fill_e.vld = 1'b1;
        u.fill_e.page_frame_number = jr.page_frame_number;
        u.fill_e.attr = jr.attr;
      end
      ST_RELOOK:
      begin
        // a table write in ST_JLOOK flushed the fill, so look again
        if (u.hit)
        begin
          nxt_q.done = 1'b1;
          nxt_q.paddr = {u.page_frame_number, q_ff.dva[11:0]};
          nxt_q.attr = u.attr;
          nxt_q.st = ST_IDLE;
        end
        else
          nxt_q.st = ST_JLOOK;
      end
    endcase
    nxt_q.cls = cca_decode(nxt_q.attr);
    nxt_q.busy = nxt_q.st != ST_IDLE;

    if (igo)
    begin
      nxt_q.idone = 1'b1;
      nxt_q.ipfn = jr.page_frame_number;
      nxt_q.iattr = jr.attr;
      nxt_q.irexc = !jr.hit;
      nxt_q.iinv = jr.hit && !jr.v;
      nxt_q.ipend = 1'b0;
    end
    if (if_req)
    begin
      nxt_q.ipend = 1'b1;
      nxt_q.iva = if_vaddr;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q_ff <= '0;
      q_ff.cfg <= `MMUAT_CFG_RST;
      q_ff.error_level_bit <= `MMUAT_ERL_RST;
      q_ff.rnd <= TOP;
      q_ff.cls <= CCA_WT_NOALLOC;
      q_ff.st <= ST_IDLE;
    end
    else if (clk_en)
      q_ff <= nxt_q;
  end

  assign reg_rdata = q_ff.rdata;
  assign ls_busy = q_ff.busy;
  assign ls_done = q_ff.done;
  assign ls_paddr = q_ff.paddr;
  assign ls_attr = q_ff.attr;
  assign ls_cls = q_ff.cls;
  assign ls_refill_exc = q_ff.rexc;
  assign ls_invalid_exc = q_ff.dinv;
  assign ls_addr_err = q_ff.aerr;
  assign if_done = q_ff.idone;
  assign if_pfn = q_ff.ipfn;
  assign if_attr = q_ff.iattr;
  assign if_refill_exc = q_ff.irexc;
  assign if_invalid_exc = q_ff.iinv;
  assign mcheck_exc = q_ff.mchk;
endmodule
`default_nettype wire

// *** test/mmuat_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mmuat_defines.svh"
module mmuat_top_properties
  import mmuat_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic ls_req,
  input wire logic ls_busy,
  input wire logic ls_done,
  input wire logic [35:0] ls_paddr,
  input wire logic [2:0] ls_attr,
  input wire mmuat_cca_t ls_cls,
  input wire logic ls_refill_exc,
  input wire logic ls_invalid_exc,
  input wire logic ls_addr_err,
  input wire logic if_req,
  input wire logic if_done,
  input wire logic mcheck_exc
);
  // ****************************************
  // translation timing and outputs
  // ****************************************
  default clocking @(posedge clk);
  endclocking
  // a frozen clock enable stretches pulses, so nothing is judged then
  default disable iff (!reset_n || !clk_en);
  sequence take_s;
    ls_req && !ls_busy;
  endsequence
  sequence both_miss_s;
    (ls_req && !ls_busy && if_req) ##1 ls_busy;
  endsequence
  req_answer_a: assert property (take_s |=> ls_done || ls_busy)
    else $error("request left unanswered");
  miss_bound_a: assert property ($rose(ls_busy) |-> ##[1:4] ls_done)
    else $error("miss not resolved in time");
  busy_end_a: assert property ($fell(ls_busy) |-> ls_done)
    else $error("busy dropped without answer");
  exc_done_a: assert property ((ls_refill_exc || ls_invalid_exc || ls_addr_err) |-> ls_done)
    else $error("exception without done");
  held_out_a: assert property (($changed(ls_paddr) || $changed(ls_attr)) |-> ls_done)
    else $error("translation changed without done");
  cls_decode_a: assert property (ls_cls == (ls_attr == 3'h7 ? CCA_UNC_ACCEL :
    ls_attr > 3'h2 ? CCA_WRITE_BACK : mmuat_cca_t'(ls_attr))) else $error("attribute class wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 64'h0)
    else $error("read data outside read slot");
  data_first_a: assert property (both_miss_s |-> !if_done[*2] ##1 if_done)
    else $error("instruction fill not after data");
  if_fill_a: assert property (if_req |=> !if_done ##[1:2] if_done)
    else $error("instruction fill latency wrong");
  mcheck_cause_a: assert property (mcheck_exc |-> $past(reg_wr) && $past(reg_addr) == `MMUAT_A_CMD)
    else $error("machine check without write");
endmodule
bind mmuat_top mmuat_top_properties i_props (.clk, .reset_n, .clk_en, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .ls_req, .ls_busy, .ls_done, .ls_paddr, .ls_attr, .ls_cls, .ls_refill_exc,
  .ls_invalid_exc, .ls_addr_err, .if_req, .if_done, .mcheck_exc);
`default_nettype wire

// *** test/mmuat_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmuat_pipe_model
(
  input wire logic clk,
  input wire logic ls_busy,
  input wire logic if_done,
  output logic ls_req,
  output logic [63:0] ls_vaddr,
  output logic if_req,
  output logic [63:0] if_vaddr
);
  // ****************************************
  // address generation side
  // ****************************************
  initial
  begin
    ls_req = 1'b0;
    if_req = 1'b0;
    ls_vaddr = 64'h0;
    if_vaddr = 64'h0;
  end
  // busy is read at the falling edge, where it is settled
  task automatic load(input logic [63:0] va, output time t);
    @(negedge clk);
    while (ls_busy !== 1'b0)
      @(negedge clk);
    @(posedge clk);
    t = $time;
    ls_req <= 1'b1;
    ls_vaddr <= va;
    @(posedge clk);
    ls_req <= 1'b0;
    ls_vaddr <= ~va;
  endtask
  // one fill outstanding: returns only once the answer was seen
  task automatic fetch(input logic [63:0] va);
    @(negedge clk);
    @(posedge clk);
    if_req <= 1'b1;
    if_vaddr <= va;
    @(posedge clk);
    if_req <= 1'b0;
    if_vaddr <= ~va;
    while (if_done !== 1'b1)
      @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** test/mmuat_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mmuat_defines.svh"
module mmuat_top_tb
  import mmuat_pkg::*;
;
  typedef struct {logic [41:0] v; time due;} mmuat_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [63:0] reg_rdata, ls_vaddr, if_vaddr;
  logic ls_req, ls_busy, ls_done, ls_refill_exc, ls_invalid_exc, ls_addr_err;
  logic if_req, if_done, if_refill_exc, if_invalid_exc, mcheck_exc;
  logic [35:0] ls_paddr;
  logic [2:0] ls_attr, if_attr, uk, us, kc, ra, rb;
  logic [23:0] if_pfn;
  mmuat_cca_t ls_cls;
  mmuat_note_t lq[$];
  mmuat_note_t nt;
  logic [63:0] rq[$];
  int error_cnt = 0;
  int n_checks = 0;
  logic rd_q = 1'b0;
  logic [35:0] lpa = 36'h0;
  logic [2:0] la = 3'h0;
  mmuat_top #(.USE_FMT(1'b0), .JOINT_TRANSLATION_BUFFER_PAIRS(16), .UTLB_ENTRIES(4)) i_dut (.clk, .reset_n, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ls_req, .ls_vaddr, .ls_busy, .ls_done,
    .ls_paddr, .ls_attr, .ls_cls, .ls_refill_exc, .ls_invalid_exc, .ls_addr_err, .if_req, .if_vaddr,
    .if_done, .if_pfn, .if_attr, .if_refill_exc, .if_invalid_exc, .mcheck_exc);
  mmuat_pipe_model i_pipe (.clk, .ls_busy, .if_done, .ls_req, .ls_vaddr, .if_req, .if_vaddr);
  // ****************************************
  // checking and bus tasks
  // ****************************************
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_q <= reg_rd;
    if (rd_q)
      check(reg_rdata, rq.pop_front());
    if (ls_done === 1'b1)
    begin
      nt = lq.pop_front();
      check({22'h0, ls_refill_exc, ls_invalid_exc, ls_addr_err, ls_paddr, ls_attr}, {22'h0, nt.v});
      check(64'($time), 64'(nt.due));
    end
  end
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [63:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ent(input logic [63:0] idx, input logic [63:0] ehi, input logic [23:0] p0,
    input logic [23:0] p1, input logic [2:0] a0, input logic [2:0] a1, input logic g,
    input logic [63:0] pm, input logic [63:0] cmd);
    wr(`MMUAT_A_EHI, ehi);
    wr(`MMUAT_A_LO0, {34'h0, p0, a0, 2'h1, g});
    wr(`MMUAT_A_LO1, {34'h0, p1, a1, 2'h1, g});
    wr(`MMUAT_A_PMASK, pm);
    wr(`MMUAT_A_INDEX, idx);
    wr(`MMUAT_A_CMD, cmd);
  endtask
  // exceptions leave the last good translation on the outputs
  task automatic xl(input logic [63:0] va, input int n, input logic [2:0] fl, input logic [35:0] pa,
    input logic [2:0] at);
    time t;
    if (fl == 3'h0)
    begin
      lpa = pa;
      la = at;
    end
    i_pipe.load(va, t);
    lq.push_back('{{fl, lpa, la}, t + (n + 1) * 10});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'h84aa));
    uk = 3'($urandom);
    us = 3'($urandom);
    kc = 3'($urandom);
    ra = 3'($urandom);
    rb = 3'($urandom);
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`MMUAT_A_CONFIG, 64'h2400_0002);
    rd(`MMUAT_A_STATUS, 64'h4);
    rd(8'h50, 64'h0);
    wr(`MMUAT_A_CONFIG, {33'h0, uk, us, 22'h0, kc});
    rd(`MMUAT_A_CONFIG, {33'h0, uk, us, 22'h0, kc});
    xl(64'h0000_0000_1234_5678, 1, 3'h0, 36'h0_1234_5678, 3'h2);
    xl(64'hFFFF_FFFF_8765_4321, 1, 3'h0, 36'h0_0765_4321, kc);
    xl(64'hFFFF_FFFF_A123_4567, 1, 3'h0, 36'h0_0123_4567, 3'h2);
    xl(64'h0000_0100_0000_0000, 1, 3'h1, 36'h0, 3'h0);
    wr(`MMUAT_A_STATUS, 64'h0);
    xl(64'h0040_0000, 2, 3'h4, 36'h0, 3'h0);
    ent(64'h0, 64'h0040_0011, 24'h000ABC, 24'h000DEF, ra, rb, 1'b0, 64'h0, 64'h1);
    xl(64'h0040_0123, 3, 3'h0, 36'h0_00AB_C123, ra);
    xl(64'h0040_1FED, 3, 3'h0, 36'h0_00DE_FFED, rb);
    xl(64'h0040_0456, 1, 3'h0, 36'h0_00AB_C456, ra);
    wr(`MMUAT_A_EHI, 64'h0040_0022);
    xl(64'h0040_0123, 2, 3'h4, 36'h0, 3'h0);
    ent(64'h1, 64'h0080_0022, 24'h000123, 24'h000456, 3'h3, 3'h7, 1'b1, 64'h0, 64'h1);
    wr(`MMUAT_A_EHI, 64'h0080_0033);
    xl(64'h0080_0010, 3, 3'h0, 36'h0_0012_3010, 3'h3);
    xl(64'h0080_1010, 3, 3'h0, 36'h0_0045_6010, 3'h7);
    ent(64'h2, 64'h0040_0011, 24'h000555, 24'h000666, 3'h0, 3'h1, 1'b0, 64'h0, 64'h1);
    rd(`MMUAT_A_STATUS, 64'h20_0000);
    xl(64'h0040_0010, 3, 3'h0, 36'h0_00AB_C010, ra);
    wr(`MMUAT_A_STATUS, 64'h0);
    rd(`MMUAT_A_STATUS, 64'h0);
    ent(64'h3, 64'h4000_0011, 24'h003000, 24'h005000, 3'h5, 3'h1, 1'b0, 64'h01FF_E000, 64'h1);
    wr(`MMUAT_A_PMASK, 64'h0);
    xl(64'h4123_4567, 3, 3'h0, 36'h0_0523_4567, 3'h1);
    wr(`MMUAT_A_WIRED, 64'hF);
    ent(64'h0, 64'h0100_0011, 24'h000777, 24'h000888, 3'h3, 3'h3, 1'b0, 64'h0, 64'h2);
    ent(64'h0, 64'h0200_0011, 24'h000999, 24'h000AAA, 3'h3, 3'h3, 1'b0, 64'h0, 64'h2);
    xl(64'h0100_0000, 2, 3'h4, 36'h0, 3'h0);
    xl(64'h0200_0000, 3, 3'h0, 36'h0_0099_9000, 3'h3);
    // let the last miss drain so both requests meet at one edge
    repeat (3) @(posedge clk);
    fork
      xl(64'h0040_0010, 3, 3'h0, 36'h0_00AB_C010, ra);
      i_pipe.fetch(64'h0080_0020);
    join
    check({35'h0, if_refill_exc, if_invalid_exc, if_pfn, if_attr}, {37'h0, 24'h000123, 3'h3});
    // frozen block must ignore the strobe and keep read data at zero
    clk_en <= 1'b0;
    rd(`MMUAT_A_CONFIG, 64'h0);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    check(64'(lq.size()), 64'h0);
    summarize();
  end
  initial
  begin
    #50us;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
